// ### hw/pmip_pkg.sv
// Package for the management interrupt pend block
package pmip_pkg;
	localparam int PMIP_VEC_W = 4;
	localparam int PMIP_NUM_VEC = 16;
	localparam logic [3:0] PMIP_PIN_VEC = 4'h0;
	localparam logic [3:0] PMIP_PLAT_MAX = 4'h3;
	localparam logic [2:0] PMIP_MODE_PMI = 3'h2;
	localparam int PMIP_ADDR_W = 64;

	typedef struct packed {
		logic valid;
		logic [2:0] mode;
		logic [7:0] dest;
		logic [3:0] vector;
	} pmip_ipi_msg_s;

	typedef struct packed {
		logic [PMIP_ADDR_W-1:0] resume_ip;
		logic [3:0] vector;
	} pmip_ctx_s;

	typedef enum logic [2:0] {
		PMIP_IDLE = 3'b001,
		PMIP_ENTER = 3'b010,
		PMIP_IN_SVC = 3'b100
	} pmip_state_e;
endpackage : pmip_pkg

// ### hw/pmip_pend.sv
// Management interrupt pending and firmware entry sequencing
//
// Behaviour
// - Management vectors are pended apart from ordinary external interrupt numbering.
// - Vectors 0 to 3 always exist and serve platform firmware.
// - Vectors 4 to 15 are kept for processor firmware only.
// - Asserted request pin pends vector zero.
// - Accepted at any time and ranked above every external interrupt.
// - Management-mode message to this processor pends its carried vector if that vector is 0 to 3.
// - Servicing a pending vector jumps to the firmware service entry point.
// - Interrupted instruction address is saved for later resumption.
// - Each vector has its own pending bit.
`timescale 1ns/1ns
module pmip_pend
	import pmip_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_mgmt_req_pin,
	input wire pmip_ipi_msg_s i_ipi_msg,
	input wire logic [7:0] i_my_id,
	input wire logic i_fw_req_valid,
	input wire logic [3:0] i_fw_req_vector,
	input wire logic i_ext_int_req,
	input wire logic [PMIP_ADDR_W-1:0] i_cur_ip,
	input wire logic i_can_take,
	input wire logic i_svc_done,
	output logic o_firmware_service_entry,
	output logic o_ext_int_take,
	output logic o_in_service,
	output pmip_ctx_s o_ctx,
	output logic [PMIP_NUM_VEC-1:0] o_pending,
	output logic o_resume,
	output logic [PMIP_ADDR_W-1:0] o_resume_ip
);
	function automatic logic [PMIP_NUM_VEC-1:0] vec_onehot(input logic [3:0] v);
		vec_onehot = '0;
		vec_onehot[v] = 1'b1;
	endfunction : vec_onehot

	pmip_state_e state_q, state_d;
	logic [PMIP_NUM_VEC-1:0] pend_q, pend_d;
	pmip_ctx_s ctx_q;
	logic entry_q;
	logic resume_q;

	wire logic ipi_hit;
	wire logic ipi_ok;
	wire logic fw_ok;
	wire logic [PMIP_NUM_VEC-1:0] set_vec;
	wire logic any_pend;
	wire logic take;
	wire logic [3:0] sel_vec;
	wire logic [PMIP_NUM_VEC-1:0] clr_vec;

	// Message aimed at us in management mode
	assign ipi_hit = i_ipi_msg.valid && (i_ipi_msg.mode == PMIP_MODE_PMI)
		&& (i_ipi_msg.dest == i_my_id);
	// Messages carry platform vectors only
	assign ipi_ok = ipi_hit && (i_ipi_msg.vector <= PMIP_PLAT_MAX);
	// Upper vectors only from processor firmware
	assign fw_ok = i_fw_req_valid && (i_fw_req_vector > PMIP_PLAT_MAX);
	assign set_vec = (i_mgmt_req_pin ? vec_onehot(PMIP_PIN_VEC) : '0)
		| (ipi_ok ? vec_onehot(i_ipi_msg.vector) : '0)
		| (fw_ok ? vec_onehot(i_fw_req_vector) : '0);
	assign any_pend = |pend_q;

	// Lowest vector number wins
	function automatic logic [3:0] low_vec(input logic [PMIP_NUM_VEC-1:0] p);
		low_vec = '0;
		for (int i = PMIP_NUM_VEC - 1; i >= 0; i--) begin
			if (p[i]) begin
				low_vec = 4'(i);
			end
		end
	endfunction : low_vec

	assign sel_vec = low_vec(pend_q);
	assign take = (state_q == PMIP_IDLE) && any_pend && i_can_take;
	assign clr_vec = take ? vec_onehot(sel_vec) : '0;
	// Set wins over clear; repeats merge into one bit
	assign pend_d = (pend_q & ~clr_vec) | set_vec;

	always_comb begin
		state_d = state_q;
		case (state_q)
			PMIP_IDLE: begin
				if (take) begin
					state_d = PMIP_ENTER;
				end
			end
			PMIP_ENTER: begin
				state_d = PMIP_IN_SVC;
			end
			PMIP_IN_SVC: begin
				if (i_svc_done) begin
					state_d = PMIP_IDLE;
				end
			end
			default: begin
				state_d = PMIP_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			state_q <= PMIP_IDLE;
			pend_q <= '0;
			ctx_q <= '0;
			entry_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pend_q <= pend_d;
			entry_q <= take;
			resume_q <= (state_q == PMIP_IN_SVC) && i_svc_done;
			if (take) begin
				ctx_q <= '{resume_ip: i_cur_ip, vector: sel_vec};
			end
		end
	end

	// External interrupts wait while any management work exists
	assign o_ext_int_take = i_ext_int_req && i_can_take && !any_pend
		&& (state_q == PMIP_IDLE);
	assign o_firmware_service_entry = entry_q;
	assign o_in_service = (state_q != PMIP_IDLE);
	assign o_ctx = ctx_q;
	assign o_pending = pend_q;
	assign o_resume = resume_q;
	assign o_resume_ip = ctx_q.resume_ip;
endmodule : pmip_pend

// ### verification/pmip_pend_asserts.sv
// Checker
`timescale 1ns/1ns
module pmip_pend_chk import pmip_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_mgmt_req_pin,
	input wire pmip_ipi_msg_s i_ipi_msg,
	input wire logic [7:0] i_my_id,
	input wire logic i_can_take,
	input wire logic i_svc_done,
	input wire logic o_firmware_service_entry,
	input wire logic o_ext_int_take,
	input wire logic o_in_service,
	input wire logic [PMIP_NUM_VEC-1:0] o_pending,
	input wire logic o_resume
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	// Core ready and idle with work waiting
	sequence s_take;
		!o_in_service && i_can_take && (|o_pending);
	endsequence
	// Done pulse while in service, past entry
	sequence s_done;
		o_in_service && !o_firmware_service_entry && i_svc_done;
	endsequence
	// Platform message aimed here
	sequence s_msg;
		i_ipi_msg.valid && (i_ipi_msg.mode == PMIP_MODE_PMI) && (i_ipi_msg.dest == i_my_id)
			&& (i_ipi_msg.vector <= PMIP_PLAT_MAX);
	endsequence
	a_pin_pends: assert property (i_mgmt_req_pin |=> o_pending[0]) else $error("pin");
	a_svc_entry: assert property ($rose(o_in_service) |-> o_firmware_service_entry)
		else $error("entry");
	a_take_enters: assert property (s_take |=> o_firmware_service_entry)
		else $error("no entry after take");
	a_entry_pulse: assert property (o_firmware_service_entry |=> !o_firmware_service_entry)
		else $error("entry not a pulse");
	a_done_resumes: assert property (s_done |=> (o_resume && !o_in_service))
		else $error("no resume after done");
	a_ext_blocked: assert property ((|o_pending || o_in_service) |-> !o_ext_int_take)
		else $error("external taken over management");
	a_msg_pends: assert property (s_msg |=> o_pending[$past(i_ipi_msg.vector)])
		else $error("message vector not pended");
endmodule : pmip_pend_chk

// ### verification/pmip_plat.sv
// Sender model
`timescale 1ns/1ns
module pmip_plat import pmip_pkg::*; (
	input wire logic i_go,
	output pmip_ipi_msg_s o_msg
);
	assign o_msg = '{i_go, PMIP_MODE_PMI, 8'h05, 4'h2};
endmodule : pmip_plat

// ### verification/test_pmip_pend.sv
// Bench
`timescale 1ns/1ns
module test_pmip_pend import pmip_pkg::*;;
	logic c = 0, r = 0, p = 0, g = 0, t = 0, d = 0, f = 0, e, k, s, u;
	logic [3:0] fv = 4'h0;
	pmip_ipi_msg_s m;
	pmip_ctx_s x;
	logic [15:0] q;
	int bad_count = 0, total_checks = 0, n = 0;
	always #4 c = ~c;
	pmip_plat pmip_plat_inst(.i_go(g), .o_msg(m));
	pmip_pend pmip_pend_inst(.i_ref_clk(c), .i_rst_b(r), .i_mgmt_req_pin(p), .i_ipi_msg(m),
		.i_my_id(8'h05), .i_fw_req_valid(f), .i_fw_req_vector(fv), .i_ext_int_req(1'b1),
		.i_cur_ip(64'hA0), .i_can_take(t), .i_svc_done(d), .o_firmware_service_entry(e),
		.o_ext_int_take(k), .o_in_service(s), .o_ctx(x), .o_pending(q), .o_resume(u),
		.o_resume_ip());
	task chk(string w, logic [84:0] a, b);
		total_checks++;
		bad_count += (a !== b);
		if (a !== b) $display("MISMATCH %s %0h %0h", w, b, a);
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	always @(posedge c) if (++n == 500) begin
		bad_count++;
		end_sim;
	end
	task t_pend;
		@(posedge c) p <= 1;
		@(posedge c) p <= 0;
		g <= 1;
		@(posedge c) g <= 0;
		#1 chk("pend", q, 85'h5);
		$display("pend");
	endtask : t_pend
	task t_take;
		@(posedge c) t <= 1;
		@(posedge c) t <= 0;
		#1 chk("ctx", {e, x, q}, {1'b1, 64'hA0, 4'h0, 16'h4});
		@(posedge c) d <= 1;
		#1 chk("svc", {e, s}, 2'h1);
		@(posedge c) d <= 0;
		#1 chk("res", {u, s, k}, 3'h4);
		$display("take");
	endtask : t_take
	task t_take2;
		@(posedge c) t <= 1;
		@(posedge c) t <= 0;
		#1 chk("ctx2", {e, x.vector, q}, {1'b1, 4'h2, 16'h0});
		@(posedge c) d <= 1;
		@(posedge c) d <= 0;
		t <= 1;
		#1 chk("ext", {u, s, k}, 3'h5);
		@(posedge c) t <= 0;
		$display("take2");
	endtask : t_take2
	task t_fw;
		@(posedge c) f <= 1;
		fv <= 4'h1;
		@(posedge c) fv <= 4'h5;
		@(posedge c) f <= 0;
		#1 chk("fw", q, 16'h0020);
		$display("fw");
	endtask : t_fw
	task t_reset;
		@(posedge c) r <= 0;
		p <= 1;
		@(posedge c) p <= 0;
		@(posedge c) r <= 1;
		#1 chk("rst", {u, s, e, q}, 19'h0);
		@(posedge c);
		#1 chk("rst2", {u, s, e, q}, 19'h0);
		$display("reset");
	endtask : t_reset
	initial begin
		repeat (8) @(posedge c);
		r <= 1;
		t_pend;
		t_take;
		t_take2;
		t_fw;
		t_reset;
		end_sim;
	end
endmodule : test_pmip_pend
bind pmip_pend pmip_pend_chk pmip_pend_chk_inst(.*);
